//--- design/hts_pkg.sv
// Purpose: shared constants and types for the humidity/temperature sensor register block
// Assumes: 8-bit register pointer on the two-wire bus, 16-bit conversion results
// Notes: one package, imported whole by the design module
package hts_pkg;

  // system clock rate and auto measurement period
  localparam int unsigned CLK_KHZ = 20_000;
  localparam int unsigned AUTO_PERIOD_MS = 1000;
  localparam int unsigned AUTO_PERIOD_CYC = AUTO_PERIOD_MS * CLK_KHZ;

  // bus slave address, low bit taken from the select pin
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h40;

  // register offsets
  localparam logic [7:0] OFS_TEMP_LOW = 8'h00;
  localparam logic [7:0] OFS_TEMP_HIGH = 8'h01;
  localparam logic [7:0] OFS_HUMID_LOW = 8'h02;
  localparam logic [7:0] OFS_HUMID_HIGH = 8'h03;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TEMP_PEAK = 8'h05;
  localparam logic [7:0] OFS_HUMID_PEAK = 8'h06;
  localparam logic [7:0] OFS_ALARM_EN = 8'h07;
  localparam logic [7:0] OFS_TEMP_TRIM = 8'h08;
  localparam logic [7:0] OFS_HUMID_TRIM = 8'h09;
  localparam logic [7:0] OFS_TEMP_LIM_LOW = 8'h0a;
  localparam logic [7:0] OFS_TEMP_LIM_HIGH = 8'h0b;
  localparam logic [7:0] OFS_HUMID_LIM_LOW = 8'h0c;
  localparam logic [7:0] OFS_HUMID_LIM_HIGH = 8'h0d;
  localparam logic [7:0] OFS_PIN_CFG = 8'h0e;
  localparam logic [7:0] OFS_CONV_SETUP = 8'h0f;
  localparam logic [7:0] OFS_MAKER_LOW = 8'hfc;
  localparam logic [7:0] OFS_MAKER_HIGH = 8'hfd;
  localparam logic [7:0] OFS_PART_LOW = 8'hfe;
  localparam logic [7:0] OFS_PART_HIGH = 8'hff;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LIM_HIGH = 8'hff;

  // field positions: status and alarm enable share the layout
  localparam int unsigned B_DRDY = 7;
  localparam int unsigned B_TEMP_HIGH = 6;
  localparam int unsigned B_TEMP_LOW = 5;
  localparam int unsigned B_HUMID_HIGH = 4;
  localparam int unsigned B_HUMID_LOW = 3;
  // pin configuration fields
  localparam int unsigned B_SOFT_RESET = 7;
  localparam int unsigned B_AUTO_MSB = 6;
  localparam int unsigned B_AUTO_LSB = 4;
  localparam int unsigned B_PIN_EN = 2;
  localparam int unsigned B_PIN_POL = 1;
  localparam int unsigned B_ALARM_MODE = 0;
  // conversion setup fields
  localparam int unsigned B_KIND_MSB = 2;
  localparam int unsigned B_KIND_LSB = 1;
  localparam int unsigned B_TRIGGER = 0;
  localparam logic [1:0] KIND_TEMP_ONLY = 2'h1;
  localparam logic [1:0] KIND_HUMID_ONLY = 2'h2;

  // measurement sequencer states
  typedef enum logic [3:0] {
    M_SLEEP = 4'b0001,
    M_TEMP = 4'b0010,
    M_HUMID = 4'b0100,
    M_SEND = 4'b1000
  } hts_meas_t;

  // bus slave states
  typedef enum logic [6:0] {
    I_IDLE = 7'b0000001,
    I_ADDR = 7'b0000010,
    I_ADDR_ACK = 7'b0000100,
    I_WR_BYTE = 7'b0001000,
    I_WR_ACK = 7'b0010000,
    I_RD_BYTE = 7'b0100000,
    I_RD_ACK = 7'b1000000
  } hts_bus_t;

  // one finished measurement, handed across to the bus side
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] humid;
    logic got_temp;
    logic got_humid;
  } hts_result_t;

endpackage : hts_pkg

//--- design/hts_i2c_regs.sv
// Purpose: sensor digital core: two-wire slave, register map, alarms, sleep/measure sequencing
// Assumes: adc_* on sys_clk; bus pins and select pin asynchronous; link_clk oversamples the bus
// Notes: link_clk domain holds the bus slave and registers, sys_clk domain the conversion sequencer
//
// Notes on behaviour
// - humidity-high flag sets when enabled and humidity exceeds the high limit
// - humidity-low flag sets when enabled and humidity falls below the low limit
// - latched mode keeps a set flag until the status register is read
// - comparator mode recomputes each flag from the newest conversion
// - alarm pin level follows the selected flag with programmable polarity
// - after power-up the device sleeps until a bus access starts work
// - a trigger converts, stores results, then returns to sleep
// - slave address is 1000000 with select low, 1000001 with select high
// - bus slave only, open-drain lines, never starts a transfer
// - every byte travels most significant bit first
// - first byte after a write address is the register pointer
// - reads return the register at the last written pointer
// - pointer advances after each data byte
// - data bytes written to identification registers are refused
// - a pointer byte naming an unused location is refused
// - a foreign slave address is refused
// - address, pointer and data bytes of a write are acknowledged
// - map holds locations 0x00 to 0x0f and 0xfc to 0xff
// - peak registers are frozen in automatic periodic mode
// - alarm pin shows one enabled alarm by fixed priority, not an OR
// - reading the status register clears its flags
// - alarm pin floats unless its enable bit is set
`timescale 1ns/1ps

module hts_i2c_regs
  import hts_pkg::*;
#(
  parameter int unsigned AUTO_PERIOD = AUTO_PERIOD_CYC,
  parameter logic [15:0] MAKER_CODE = 16'h5a3c, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h1234 // arbitrary value
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_sel_i,
  output logic alarm_ready_pin_o,
  output logic alarm_ready_pin_oe,
  output logic adc_start,
  output logic adc_humid_sel,
  input wire logic adc_done,
  input wire logic [15:0] adc_data,
  output logic meas_busy
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // declarations

  // sys_clk side
  hts_meas_t meas_q;
  hts_result_t res_q;
  logic [2:0] trig_sync_q;
  logic [1:0] auto_sync_q;
  logic [1:0] ack_sync_q;
  logic [1:0] kind_s1_q, kind_s2_q;
  logic req_tgl_q;
  logic adc_start_q, adc_sel_q;
  logic [31:0] auto_cnt_q;
  logic auto_tick, meas_go;

  // link_clk side
  logic [1:0] lrst_q;
  logic link_rst;
  logic [1:0] scl_s_q, sda_s_q, sel_s_q;
  logic scl_d_q, sda_d_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [2:0] req_sync_q;
  logic res_new;
  logic ack_tgl_q, trig_tgl_q;
  hts_result_t got_q;
  hts_bus_t bus_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q, tx_q, ptr_q;
  logic rw_q, ptr_phase_q, master_ack_q;
  logic sda_oe_q;
  logic [7:0] rd_data;
  logic byte_in, ptr_fire, wr_fire, rd_fire;
  logic [15:0] temp_res_q, humid_res_q;
  logic [7:3] flags_q;
  logic [7:3] alarm_en_q;
  logic [7:0] temp_peak_q, humid_peak_q, temp_trim_q, humid_trim_q;
  logic [7:0] tlim_lo_q, tlim_hi_q, hlim_lo_q, hlim_hi_q, pin_cfg_q, conv_q;
  logic [7:3] cmp;
  logic pin_lvl_q, pin_oe_q;
  logic res_apply_q;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // helpers

  // locations that exist in the map
  function automatic logic ptr_valid(input logic [7:0] p);
    ptr_valid = (p <= OFS_CONV_SETUP) || (p >= OFS_MAKER_LOW);
  endfunction : ptr_valid

  // locations that accept data
  function automatic logic ptr_writable(input logic [7:0] p);
    ptr_writable = (p >= OFS_TEMP_PEAK) && (p <= OFS_CONV_SETUP);
  endfunction : ptr_writable

  ////////////////////////////////////////////////////////////////////////////////////////////
  // sys_clk: crossings into the sequencer

  // trigger toggle three flops (two plus edge delay); auto enable level, ack toggle and kind bits two flops each
  always_ff @(posedge sys_clk)
  begin
    trig_sync_q <= {trig_sync_q[1:0], trig_tgl_q};
    auto_sync_q <= {auto_sync_q[0], |pin_cfg_q[B_AUTO_MSB:B_AUTO_LSB]};
    ack_sync_q <= {ack_sync_q[0], ack_tgl_q};
    kind_s1_q <= conv_q[B_KIND_MSB:B_KIND_LSB];
    kind_s2_q <= kind_s1_q;
  end

  // periodic wake-up in automatic mode
  always_ff @(posedge sys_clk)
  begin
    if (rst || !auto_sync_q[1] || auto_tick)
      auto_cnt_q <= '0;
    else
      auto_cnt_q <= auto_cnt_q + 32'h0000_0001;
  end

  assign auto_tick = auto_sync_q[1] && (auto_cnt_q == AUTO_PERIOD - 1);
  assign meas_go = (trig_sync_q[2] ^ trig_sync_q[1]) || auto_tick;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // sys_clk: measurement sequencer

  // sleep until started, convert, hand over, sleep again
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meas_q <= M_SLEEP;
      adc_start_q <= 1'b0;
      adc_sel_q <= 1'b0;
      req_tgl_q <= 1'b0;
    end
    else
    begin
      adc_start_q <= 1'b0;
      unique case (meas_q)
        M_SLEEP:
          if (meas_go)
          begin
            adc_start_q <= 1'b1;
            adc_sel_q <= (kind_s2_q == KIND_HUMID_ONLY);
            meas_q <= (kind_s2_q == KIND_HUMID_ONLY) ? M_HUMID : M_TEMP;
          end
        M_TEMP:
          if (adc_done)
          begin
            if (kind_s2_q == KIND_TEMP_ONLY)
            begin
              req_tgl_q <= ~req_tgl_q;
              meas_q <= M_SEND;
            end
            else
            begin
              adc_start_q <= 1'b1;
              adc_sel_q <= 1'b1;
              meas_q <= M_HUMID;
            end
          end
        M_HUMID:
          if (adc_done)
          begin
            req_tgl_q <= ~req_tgl_q;
            meas_q <= M_SEND;
          end
        M_SEND:
          if (ack_sync_q[1] == req_tgl_q)
            meas_q <= M_SLEEP;
      endcase
    end
  end

  // result words held stable until the bus side acknowledges
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      res_q <= '0;
    else if (meas_q == M_SLEEP && meas_go)
    begin
      res_q.got_temp <= 1'b0;
      res_q.got_humid <= 1'b0;
    end
    else if (adc_done && meas_q == M_TEMP)
    begin
      res_q.temp <= adc_data;
      res_q.got_temp <= 1'b1;
    end
    else if (adc_done && meas_q == M_HUMID)
    begin
      res_q.humid <= adc_data;
      res_q.got_humid <= 1'b1;
    end
  end

  assign adc_start = adc_start_q;
  assign adc_humid_sel = adc_sel_q;
  assign meas_busy = (meas_q != M_SLEEP);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // link_clk: reset, pin sampling, result crossing

  // reset and pins pass two flops, then one delay stage for edges
  always_ff @(posedge link_clk)
  begin
    lrst_q <= {lrst_q[0], rst};
    scl_s_q <= {scl_s_q[0], scl_i};
    sda_s_q <= {sda_s_q[0], sda_i};
    sel_s_q <= {sel_s_q[0], addr_sel_i};
    scl_d_q <= scl_s_q[1];
    sda_d_q <= sda_s_q[1];
    req_sync_q <= {req_sync_q[1:0], req_tgl_q};
  end

  assign link_rst = lrst_q[1];
  assign scl_rise = scl_s_q[1] && !scl_d_q;
  assign scl_fall = !scl_s_q[1] && scl_d_q;
  assign bus_start = scl_s_q[1] && scl_d_q && sda_d_q && !sda_s_q[1];
  assign bus_stop = scl_s_q[1] && scl_d_q && !sda_d_q && sda_s_q[1];
  assign res_new = req_sync_q[2] ^ req_sync_q[1];

  // capture the stable result and return the acknowledge toggle
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      got_q <= '0;
      ack_tgl_q <= 1'b0;
    end
    else if (res_new)
    begin
      got_q <= res_q;
      ack_tgl_q <= req_sync_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // link_clk: bus slave

  assign byte_in = (bus_q == I_WR_BYTE) && scl_fall && (bit_cnt_q == 4'h8);
  assign ptr_fire = byte_in && ptr_phase_q;
  assign wr_fire = byte_in && !ptr_phase_q && ptr_writable(ptr_q);
  assign rd_fire = scl_fall && (((bus_q == I_ADDR_ACK) && rw_q) || ((bus_q == I_RD_ACK) && master_ack_q));

  // byte engine; acks pull sda low, refusals simply leave it released
  always_ff @(posedge link_clk)
  begin
    if (link_rst || bus_stop)
    begin
      bus_q <= I_IDLE;
      sda_oe_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      rw_q <= 1'b0;
      ptr_phase_q <= 1'b0;
      master_ack_q <= 1'b0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
    end
    else if (bus_start)
    begin
      bus_q <= I_ADDR;
      sda_oe_q <= 1'b0;
      bit_cnt_q <= 4'h0;
    end
    else
    begin
      unique case (bus_q)
        I_IDLE: ;
        I_ADDR, I_WR_BYTE:
          if (scl_rise && bit_cnt_q != 4'h8)
          begin
            rx_q <= {rx_q[6:0], sda_s_q[1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (scl_fall && bit_cnt_q == 4'h8)
          begin
            bit_cnt_q <= 4'h0;
            if (bus_q == I_ADDR)
            begin
              if (rx_q[7:1] == {SLAVE_ADDR_BASE[6:1], sel_s_q[1]})
              begin
                sda_oe_q <= 1'b1;
                rw_q <= rx_q[0];
                bus_q <= I_ADDR_ACK;
              end
              else
                bus_q <= I_IDLE;
            end
            else if ((ptr_phase_q && ptr_valid(rx_q)) || wr_fire)
            begin
              sda_oe_q <= 1'b1;
              bus_q <= I_WR_ACK;
            end
            else
              bus_q <= I_IDLE;
          end
        I_ADDR_ACK:
          if (scl_fall)
          begin
            if (rw_q)
            begin
              tx_q <= rd_data;
              sda_oe_q <= !rd_data[7];
              bus_q <= I_RD_BYTE;
            end
            else
            begin
              sda_oe_q <= 1'b0;
              ptr_phase_q <= 1'b1;
              bus_q <= I_WR_BYTE;
            end
          end
        I_WR_ACK:
          if (scl_fall)
          begin
            sda_oe_q <= 1'b0;
            ptr_phase_q <= 1'b0;
            bus_q <= I_WR_BYTE;
          end
        I_RD_BYTE:
          if (scl_rise)
            bit_cnt_q <= bit_cnt_q + 4'h1;
          else if (scl_fall)
          begin
            if (bit_cnt_q == 4'h8)
            begin
              sda_oe_q <= 1'b0;
              bit_cnt_q <= 4'h0;
              bus_q <= I_RD_ACK;
            end
            else
            begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe_q <= !tx_q[6];
            end
          end
        I_RD_ACK:
          if (scl_rise)
            master_ack_q <= !sda_s_q[1];
          else if (scl_fall)
          begin
            if (master_ack_q)
            begin
              tx_q <= rd_data;
              sda_oe_q <= !rd_data[7];
              bus_q <= I_RD_BYTE;
            end
            else
              bus_q <= I_IDLE;
          end
      endcase
    end
  end

  // register pointer
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      ptr_q <= OFS_TEMP_LOW;
    else if (ptr_fire && ptr_valid(rx_q))
      ptr_q <= rx_q;
    else if (wr_fire || rd_fire)
      ptr_q <= ptr_q + 8'h01;
  end

  // lines are open-drain: data only ever pulled low, clock never driven
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign scl_o = 1'b0;
  assign scl_oe = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // link_clk: register map

  // read mux at the current pointer
  always_comb
  begin
    unique case (ptr_q)
      OFS_TEMP_LOW: rd_data = temp_res_q[7:0];
      OFS_TEMP_HIGH: rd_data = temp_res_q[15:8];
      OFS_HUMID_LOW: rd_data = humid_res_q[7:0];
      OFS_HUMID_HIGH: rd_data = humid_res_q[15:8];
      OFS_STATUS: rd_data = {flags_q, 3'h0};
      OFS_TEMP_PEAK: rd_data = temp_peak_q;
      OFS_HUMID_PEAK: rd_data = humid_peak_q;
      OFS_ALARM_EN: rd_data = {alarm_en_q, 3'h0};
      OFS_TEMP_TRIM: rd_data = temp_trim_q;
      OFS_HUMID_TRIM: rd_data = humid_trim_q;
      OFS_TEMP_LIM_LOW: rd_data = tlim_lo_q;
      OFS_TEMP_LIM_HIGH: rd_data = tlim_hi_q;
      OFS_HUMID_LIM_LOW: rd_data = hlim_lo_q;
      OFS_HUMID_LIM_HIGH: rd_data = hlim_hi_q;
      OFS_PIN_CFG: rd_data = pin_cfg_q;
      OFS_CONV_SETUP: rd_data = conv_q;
      OFS_MAKER_LOW: rd_data = MAKER_CODE[7:0];
      OFS_MAKER_HIGH: rd_data = MAKER_CODE[15:8];
      OFS_PART_LOW: rd_data = PART_CODE[7:0];
      OFS_PART_HIGH: rd_data = PART_CODE[15:8];
      default: rd_data = RST_ZERO;
    endcase
  end

  // threshold compares on upper result bytes of the arriving conversion
  always_comb
  begin
    cmp = '0;
    cmp[B_TEMP_HIGH] = got_q.got_temp && (got_q.temp[15:8] > tlim_hi_q);
    cmp[B_TEMP_LOW] = got_q.got_temp && (got_q.temp[15:8] < tlim_lo_q);
    cmp[B_HUMID_HIGH] = got_q.got_humid && (got_q.humid[15:8] > hlim_hi_q);
    cmp[B_HUMID_LOW] = got_q.got_humid && (got_q.humid[15:8] < hlim_lo_q);
    cmp = cmp & alarm_en_q;
  end

  // software writes, soft reset, trigger toggle
  always_ff @(posedge link_clk)
  begin
    if (link_rst || (wr_fire && ptr_q == OFS_PIN_CFG && rx_q[B_SOFT_RESET]))
    begin
      alarm_en_q <= '0;
      temp_trim_q <= RST_ZERO;
      humid_trim_q <= RST_ZERO;
      tlim_lo_q <= RST_ZERO;
      tlim_hi_q <= RST_LIM_HIGH;
      hlim_lo_q <= RST_ZERO;
      hlim_hi_q <= RST_LIM_HIGH;
      pin_cfg_q <= RST_ZERO;
      conv_q <= RST_ZERO;
      trig_tgl_q <= link_rst ? 1'b0 : trig_tgl_q;
    end
    else if (wr_fire)
    begin
      unique case (ptr_q)
        OFS_ALARM_EN: alarm_en_q <= rx_q[7:3];
        OFS_TEMP_TRIM: temp_trim_q <= rx_q;
        OFS_HUMID_TRIM: humid_trim_q <= rx_q;
        OFS_TEMP_LIM_LOW: tlim_lo_q <= rx_q;
        OFS_TEMP_LIM_HIGH: tlim_hi_q <= rx_q;
        OFS_HUMID_LIM_LOW: hlim_lo_q <= rx_q;
        OFS_HUMID_LIM_HIGH: hlim_hi_q <= rx_q;
        OFS_PIN_CFG: pin_cfg_q <= rx_q;
        OFS_CONV_SETUP:
        begin
          conv_q <= {rx_q[7:1], 1'b0}; // trigger bit self-clears
          if (rx_q[B_TRIGGER])
            trig_tgl_q <= ~trig_tgl_q;
        end
        default: ;
      endcase
    end
  end

  // results, peaks and status flags; a new conversion beats a clearing read
  always_ff @(posedge link_clk)
  begin
    if (link_rst || (wr_fire && ptr_q == OFS_PIN_CFG && rx_q[B_SOFT_RESET]))
    begin
      temp_res_q <= '0;
      humid_res_q <= '0;
      temp_peak_q <= RST_ZERO;
      humid_peak_q <= RST_ZERO;
      flags_q <= '0;
    end
    else
    begin
      if (rd_fire && ptr_q == OFS_STATUS)
        flags_q <= '0;
      else if (rd_fire && ptr_q <= OFS_HUMID_HIGH)
        flags_q[B_DRDY] <= 1'b0;
      if (wr_fire && ptr_q == OFS_TEMP_PEAK)
        temp_peak_q <= rx_q;
      if (wr_fire && ptr_q == OFS_HUMID_PEAK)
        humid_peak_q <= rx_q;
      if (res_new)
        ; // data is captured this cycle, applied on the next
      if (req_sync_q[2] == ack_tgl_q && got_q != '0 && res_apply_q)
      begin
        if (got_q.got_temp)
          temp_res_q <= got_q.temp;
        if (got_q.got_humid)
          humid_res_q <= got_q.humid;
        flags_q[B_DRDY] <= alarm_en_q[B_DRDY];
        if (pin_cfg_q[B_ALARM_MODE])
          flags_q[6:3] <= flags_q[6:3] & ~(rd_fire && ptr_q == OFS_STATUS ? 4'hf : 4'h0) | cmp[6:3];
        else
          flags_q[6:3] <= cmp[6:3];
        if (pin_cfg_q[B_AUTO_MSB:B_AUTO_LSB] == 3'h0)
        begin
          if (got_q.got_temp && got_q.temp[15:8] > temp_peak_q)
            temp_peak_q <= got_q.temp[15:8];
          if (got_q.got_humid && got_q.humid[15:8] > humid_peak_q)
            humid_peak_q <= got_q.humid[15:8];
        end
      end
    end
  end

  // one-cycle apply strobe following each capture
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      res_apply_q <= 1'b0;
    else
      res_apply_q <= res_new;
  end

  // alarm pin: one flag by priority, programmable polarity, floats unless enabled
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      pin_lvl_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      pin_oe_q <= pin_cfg_q[B_PIN_EN];
      if (alarm_en_q[B_TEMP_HIGH])
        pin_lvl_q <= flags_q[B_TEMP_HIGH] ~^ pin_cfg_q[B_PIN_POL];
      else if (alarm_en_q[B_TEMP_LOW])
        pin_lvl_q <= flags_q[B_TEMP_LOW] ~^ pin_cfg_q[B_PIN_POL];
      else if (alarm_en_q[B_HUMID_HIGH])
        pin_lvl_q <= flags_q[B_HUMID_HIGH] ~^ pin_cfg_q[B_PIN_POL];
      else if (alarm_en_q[B_HUMID_LOW])
        pin_lvl_q <= flags_q[B_HUMID_LOW] ~^ pin_cfg_q[B_PIN_POL];
      else
        pin_lvl_q <= flags_q[B_DRDY] ~^ pin_cfg_q[B_PIN_POL];
    end
  end

  assign alarm_ready_pin_o = pin_lvl_q;
  assign alarm_ready_pin_oe = pin_oe_q;

endmodule : hts_i2c_regs

//--- testbench/hts_i2c_regs_properties.sv
// Purpose: port properties of the sensor block
// Assumes: bound to every instance
// Notes: sda checks on link_clk; scl check, pin check and sequencer on sys_clk
`timescale 1ns/1ps

module hts_i2c_regs_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic alarm_ready_pin_oe,
  input wire logic adc_start,
  input wire logic adc_done,
  input wire logic meas_busy
);
  ////////////////////////////////////////
  // bus pins: slave only, open drain, bits stand while scl high
  a_scl_not_driven: assert property (@(posedge sys_clk) disable iff (rst) !scl_oe)
    else $error("scl driven");
  a_sda_pull_only: assert property (@(posedge link_clk) disable iff (rst) sda_oe |-> !sda_o)
    else $error("sda driven high");
  a_sda_bit_stands: assert property (@(posedge link_clk) disable iff (rst) $changed(sda_oe) |-> !scl_i)
    else $error("sda moved with scl high");
  // sleep after reset, pin floating
  a_sleep_at_reset: assert property (@(posedge sys_clk) disable iff (rst) $fell(rst) |-> !meas_busy && !adc_start)
    else $error("busy after reset");
  a_pin_floats_reset: assert property (@(posedge sys_clk) disable iff (rst) $fell(rst) |-> !alarm_ready_pin_oe)
    else $error("pin driven after reset");
  // conversion sequencing
  a_start_one_cycle: assert property (@(posedge sys_clk) disable iff (rst) adc_start |=> !adc_start)
    else $error("start pulse too long");
  a_wake_converts: assert property (@(posedge sys_clk) disable iff (rst) $rose(meas_busy) |-> ##[0:8] adc_start)
    else $error("wake without start");
  a_done_moves_on: assert property (@(posedge sys_clk) disable iff (rst)
    adc_done |-> ##[1:12] (adc_start || !meas_busy))
    else $error("no sleep after conversion");
endmodule : hts_i2c_regs_chk

bind hts_i2c_regs hts_i2c_regs_chk u_chk (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .scl_i(scl_i),
  .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .alarm_ready_pin_oe(alarm_ready_pin_oe),
  .adc_start(adc_start), .adc_done(adc_done), .meas_busy(meas_busy));

//--- testbench/hts_bus_master.sv
// Purpose: two-wire bus master model
// Assumes: lines pulled up, bench combines the levels
// Notes: tasks except stop end with the clock line pulled low; stop leaves it released
`timescale 1ns/1ps

module hts_bus_master (
  output logic scl_low,
  output logic sda_low,
  input wire logic sda_w
);
  localparam int Q = 30;
  initial scl_low = 0;
  initial sda_low = 0;
  ////////////////////////////////////////
  // one bit: data set while clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #Q scl_low = 0;
    #Q r = sda_w;
    #Q scl_low = 1;
    #Q;
  endtask : bit_io
  // start or repeated start
  task automatic start();
    sda_low = 0;
    #Q scl_low = 0;
    #Q sda_low = 1;
    #Q scl_low = 1;
    #Q;
  endtask : start
  task automatic stop();
    sda_low = 1;
    #Q scl_low = 0;
    #Q sda_low = 0;
    #Q;
  endtask : stop
  // byte out, msb first, slave ack back
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  // byte in, ack unless last
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask : rbyte
endmodule : hts_bus_master

//--- testbench/hts_i2c_regs_test.sv
// Purpose: self-checking bench for the sensor block
// Assumes: master model on the bus, conversion model here
// Notes: high limit, select pin and results random from a fixed seed; low limit fixed
`timescale 1ns/1ps

module hts_i2c_regs_test;
  logic sys_clk = 0, link_clk = 0, rst = 1, sel = 0, adc_done = 0, hsel = 0;
  logic [15:0] adc_data = 16'h0000, hv = 16'h0000;
  logic [7:0] d [4], q [12], ak, acnt = 8'h00, lo, hi;
  logic [6:0] me;
  logic scl_low, sda_low, scl_oe, sda_oe, pin, pin_oe, adc_start, hum_sel, busy;
  wire scl_w = !(scl_low | scl_oe);
  wire sda_w = !(sda_low | sda_oe);
  int bad_count = 0, n_checks = 0;
  initial forever #25 sys_clk = ~sys_clk;
  initial #1.3 forever #3 link_clk = ~link_clk;
  hts_bus_master m (.scl_low(scl_low), .sda_low(sda_low), .sda_w(sda_w));
  hts_i2c_regs #(.AUTO_PERIOD(200)) uut (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .scl_i(scl_w),
    .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .addr_sel_i(sel),
    .alarm_ready_pin_o(pin), .alarm_ready_pin_oe(pin_oe), .adc_start(adc_start), .adc_humid_sel(hum_sel),
    .adc_done(adc_done), .adc_data(adc_data), .meas_busy(busy));
  ////////////////////////////////////////
  // conversion model: result five cycles after start
  always @(negedge sys_clk)
  begin
    adc_done <= acnt == 8'h01;
    adc_data <= hsel ? hv : 16'($urandom());
    if (adc_start) hsel <= hum_sel;
    acnt <= adc_start ? 8'h05 : (acnt != 8'h00 ? acnt - 8'h01 : 8'h00);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t: saw %h want %h", $time, got, exp);
    end
  endtask : chk
  // pointer write, data writes, then optional read after repeated start
  task automatic xfer(input logic [6:0] a, input logic [7:0] p, input int nw, input int nr);
    logic r;
    ak = 8'h00;
    m.start();
    m.wbyte({a, 1'b0}, r);
    ak[0] = r;
    m.wbyte(p, r);
    ak[1] = r;
    for (int i = 0; i < nw; i++) m.wbyte(d[i], ak[2 + i]);
    if (nr > 0) m.start();
    if (nr > 0) m.wbyte({a, 1'b1}, r);
    for (int i = 0; i < nr; i++) m.rbyte(i == nr - 1, q[i]);
    m.stop();
  endtask : xfer
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // hang guard
  initial
  begin
    #500us;
    bad_count++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    void'($urandom(48));
    sel = 1'($urandom());
    me = {6'h20, sel};
    repeat (10) @(negedge sys_clk);
    rst = 0;
    repeat (20) @(negedge sys_clk);
    chk(8'(busy), 8'h00);
    xfer(me, 8'h0a, 0, 6);
    chk(ak, 8'h03);
    for (int i = 0; i < 6; i++) chk(q[i], (i == 1 || i == 3) ? 8'hff : 8'h00);
    xfer(me ^ 7'h01, 8'h0a, 0, 0);
    chk(ak, 8'h00);
    xfer(me, 8'h10, 0, 0);
    chk(ak, 8'h01);
    d[0] = 8'($urandom());
    xfer(me, 8'hfc, 1, 0);
    chk(ak, 8'h03);
    lo = 8'h10;
    hi = 8'h40 + 8'($urandom_range(127));
    // latched high alarm with active-high pin, then comparator low alarm with active-low pin
    for (int k = 0; k < 2; k++)
    begin
      d[0] = k ? 8'h08 : 8'h10;
      xfer(me, 8'h07, 1, 0);
      hv = {k ? lo - 8'h01 : hi + 8'h01, 8'($urandom())};
      d[0] = lo;
      d[1] = hi;
      d[2] = k ? 8'h04 : 8'h07;
      d[3] = 8'h05;
      xfer(me, 8'h0c, 4, 0);
      chk(ak, 8'h3f);
      repeat (40) @(negedge sys_clk);
      chk(8'(busy), 8'h00);
      chk({6'h00, pin_oe, pin}, {7'h01, !k});
      // second conversion inside both limits: latched flag holds, comparator flag drops
      hv[15:8] = lo;
      d[0] = 8'h05;
      xfer(me, 8'h0f, 1, 0);
      repeat (40) @(negedge sys_clk);
      chk(8'(pin), 8'h01);
      xfer(me, 8'h02, 0, 12);
      chk(q[0], hv[7:0]);
      chk(q[1], hv[15:8]);
      chk(q[2] & 8'h78, k ? 8'h00 : 8'h10);
      chk(q[4], hi + 8'h01);
      chk(q[10], lo);
      chk(q[11], hi);
      if (k == 0) xfer(me, 8'h04, 0, 1);
      if (k == 0) chk(q[0] & 8'h78, 8'h00);
      if (k == 0) chk(8'(pin), 8'h00);
    end
    // automatic mode: results keep arriving, the peak stays frozen
    hv[15:8] = 8'hff;
    d[0] = 8'h10;
    xfer(me, 8'h0e, 1, 0);
    repeat (500) @(negedge sys_clk);
    xfer(me, 8'h03, 0, 4);
    chk(q[0], 8'hff);
    chk(q[3], hi + 8'h01);
    // soft reset is acknowledged and restores the limits
    d[0] = 8'h80;
    xfer(me, 8'h0e, 1, 0);
    chk(ak, 8'h07);
    xfer(me, 8'h0c, 0, 2);
    chk(q[0], 8'h00);
    chk(q[1], 8'hff);
    give_verdict();
  end
endmodule : hts_i2c_regs_test
